/* rtl/tft_ctrl.v */
// Purpose: Control logic of an off-line tape field tester.
// Assumes: One 50 MHz clock; tape unit lines synchronous to it.
// Notes: Operator settings live in Wishbone registers; spring switches are pins.
// Behaviour
// - Unload pulse only with motion selector stopped.
// - Manual rewind only while auto-cycle off.
// - Auto-cycle rewinds when end-of-tape sensed.
// - Read/write status only when ready, forward.
// - Short range: durations 2 to 30 ms.
// - Long range: durations 300 ms to 6 s.
// - Start position cycles go from oscillator.
// - Go position holds go active.
// - Stop position holds go inactive.
// - Backward line; backward suppresses status commands.
// - Tracks set to one write ones.
// - Tracks set to zero are erased.
// - First selector routes read bus to hub.
// - Second independent selector to second hub.
// - Mode setting selects PE or NRZI.
// - Model setting picks mode and frequency.
// - Go line mirrored on sync hub.
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "tft_defs.vh"
module tft_ctrl #(
  parameter [19:0] MS_CYCLES = `TFT_MS_CYCLES,
  parameter [19:0] DEB_CYCLES = `TFT_DEB_CYCLES
) (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  output reg [31:0] o_wb_dat,
  output wire o_wb_ack,
  input wire i_rewind_sw,
  input wire i_unload_sw,
  input wire i_ready,
  input wire i_eot,
  input wire [8:0] i_read_bus,
  output reg o_go,
  output reg o_backward,
  output reg o_set_read,
  output reg o_set_write,
  output reg o_rewind,
  output reg o_rewind_unload,
  output reg [8:0] o_write_bus,
  output reg o_write_pulse,
  output reg o_set_nrzi,
  output reg o_scan1,
  output reg o_scan2,
  output reg o_go_hub
);
  localparam OSC_UP = 1'b0;
  localparam OSC_DOWN = 1'b1;
  localparam [19:0] LONG_TICK = `TFT_LONG_UNIT_MS * MS_CYCLES;
  reg [`TFT_CTRL_W-1:0] ctrl_q;
  reg [9:0] go_up_q;
  reg [9:0] go_down_q;
  reg [8:0] tracks_q;
  reg [7:0] scan_q;
  reg ack_q;
  reg [19:0] pre_q;
  reg [9:0] unit_q;
  reg osc_q;
  reg eot_q;
  reg [11:0] wp_cnt_q;
  reg [31:0] rd_d;
  reg go_d;
  wire rewind_press;
  wire unload_press;
  wire bus_req;
  wire wr_en;
  wire [1:0] motion;
  wire long_rng;
  wire fwd_ready;
  wire pe_eff;
  wire tick;
  wire [9:0] up_lim;
  wire [9:0] down_lim;
  wire [9:0] target;
  wire [11:0] wp_half;
  wire [31:0] wr_word;
  // Merge write data into a register under the Wishbone byte selects.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Hold a duration setting inside the range window.
  function [9:0] clamp;
    input [9:0] val;
    input [9:0] lo;
    input [9:0] hi;
    begin
      if (val < lo) begin
        clamp = lo;
      end else if (val > hi) begin
        clamp = hi;
      end else begin
        clamp = val;
      end
    end
  endfunction

  // Pick one read bus; selections past the last track read as zero.
  function scan_pick;
    input [8:0] bus;
    input [3:0] sel;
    begin
      if (sel < `TFT_NUM_TRACKS) begin
        scan_pick = bus[sel];
      end else begin
        scan_pick = 1'b0;
      end
    end
  endfunction

  // Write pulse half period for each model code.
  function [11:0] wp_period;
    input [2:0] model;
    begin
      case (model)
        3'h0: wp_period = `TFT_WP_HALF_M1;
        3'h1: wp_period = `TFT_WP_HALF_M2;
        3'h2: wp_period = `TFT_WP_HALF_M3;
        3'h3: wp_period = `TFT_WP_HALF_M4;
        3'h4: wp_period = `TFT_WP_HALF_M5;
        default: wp_period = `TFT_WP_HALF_M6;
      endcase
    end
  endfunction

  tft_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_rewind_deb (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_sw(i_rewind_sw),
    .o_press(rewind_press)
  );
  tft_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_unload_deb (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_sw(i_unload_sw),
    .o_press(unload_press)
  );

  // Single-cycle ack one edge after the request; it drops for a cycle between requests.
  assign bus_req = i_wb_cyc & i_wb_stb;
  assign o_wb_ack = ack_q;
  assign wr_en = bus_req & i_wb_we & ~ack_q;
  assign wr_word = merge(rd_d, i_wb_dat, i_wb_sel);
  assign motion = ctrl_q[`TFT_CTRL_MOTION];
  assign long_rng = ctrl_q[`TFT_CTRL_LONG];
  assign fwd_ready = i_ready & ~ctrl_q[`TFT_CTRL_BACKWARD];
  // mode bit selects PE.
  // Models below the first PE model only record NRZI, whatever the mode bit says.
  assign pe_eff = ctrl_q[`TFT_CTRL_PE] & (ctrl_q[`TFT_CTRL_MODEL] >= `TFT_MODEL_FIRST_PE);
  assign wp_half = wp_period(ctrl_q[`TFT_CTRL_MODEL]);
  // long range window.
  // Long range counts 10 ms units so one 10-bit counter covers both ranges.
  assign up_lim = long_rng ? clamp(go_up_q, `TFT_LONG_MIN, `TFT_LONG_MAX)
                           : clamp(go_up_q, `TFT_SHORT_MIN, `TFT_SHORT_MAX);
  assign down_lim = long_rng ? clamp(go_down_q, `TFT_LONG_MIN, `TFT_LONG_MAX)
                             : clamp(go_down_q, `TFT_SHORT_MIN, `TFT_SHORT_MAX);
  assign target = (osc_q == OSC_UP) ? up_lim : down_lim;
  assign tick = long_rng ? (pre_q >= LONG_TICK - 20'h00001) : (pre_q >= MS_CYCLES - 20'h00001);

  // Register writes take effect at the edge that raises ack.
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_q <= 1'b0;
      ctrl_q <= `TFT_CTRL_RESET;
      go_up_q <= `TFT_DUR_RESET;
      go_down_q <= `TFT_DUR_RESET;
      tracks_q <= `TFT_TRACKS_RESET;
      scan_q <= `TFT_SCAN_RESET;
      o_wb_dat <= 32'h00000000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      o_wb_dat <= rd_d;
      if (wr_en) begin
        case (i_wb_adr)
          `TFT_REG_CTRL: ctrl_q <= wr_word[`TFT_CTRL_W-1:0];
          `TFT_REG_GO_UP: go_up_q <= wr_word[9:0];
          `TFT_REG_GO_DOWN: go_down_q <= wr_word[9:0];
          `TFT_REG_TRACKS: tracks_q <= wr_word[8:0];
          `TFT_REG_SCAN: scan_q <= wr_word[7:0];
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  // Read mux; unmapped offsets and the status register ignore writes.
  always @* begin
    case (i_wb_adr)
      `TFT_REG_CTRL: rd_d = {22'h000000, ctrl_q};
      `TFT_REG_GO_UP: rd_d = {22'h000000, go_up_q};
      `TFT_REG_GO_DOWN: rd_d = {22'h000000, go_down_q};
      `TFT_REG_TRACKS: rd_d = {23'h000000, tracks_q};
      `TFT_REG_SCAN: rd_d = {24'h000000, scan_q};
      `TFT_REG_STATUS: rd_d = {22'h000000, o_scan2, o_scan1, pe_eff, osc_q, i_eot, i_ready,
                               o_set_write, o_set_read, o_backward, o_go};
      default: rd_d = 32'h00000000;
    endcase
  end

  // free-running oscillator.
  // The oscillator runs in every position so the start position picks it up mid-cycle.
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pre_q <= 20'h00000;
      unit_q <= 10'h000;
      osc_q <= OSC_UP;
    end else begin
      if (tick) begin
        pre_q <= 20'h00000;
        if (unit_q >= target - 10'h001) begin
          unit_q <= 10'h000;
          case (osc_q)
            OSC_UP: osc_q <= OSC_DOWN;
            OSC_DOWN: osc_q <= OSC_UP;
            default: osc_q <= OSC_UP;
          endcase
        end else begin
          unit_q <= unit_q + 10'h001;
        end
      end else begin
        pre_q <= pre_q + 20'h00001;
      end
    end
  end

  // Go line source from the motion selector.
  always @* begin
    case (motion)
      `TFT_MOT_START: go_d = (osc_q == OSC_UP);
      `TFT_MOT_GO: go_d = 1'b1;
      default: go_d = 1'b0;
    endcase
  end

  // Tape unit command lines, all registered.
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_go <= 1'b0;
      o_go_hub <= 1'b0;
      o_backward <= 1'b0;
      o_set_read <= 1'b0;
      o_set_write <= 1'b0;
      o_rewind <= 1'b0;
      o_rewind_unload <= 1'b0;
      eot_q <= 1'b0;
      o_set_nrzi <= 1'b1;
    end else begin
      o_go <= go_d;
      o_go_hub <= go_d;
      o_backward <= ctrl_q[`TFT_CTRL_BACKWARD];
      o_set_read <= fwd_ready & ~ctrl_q[`TFT_CTRL_WRITE];
      o_set_write <= fwd_ready & ctrl_q[`TFT_CTRL_WRITE];
      eot_q <= i_eot;
      // unit needs ready.
      // The tape unit ignores rewind when not ready, so no extra wait is kept here.
      o_rewind <= ctrl_q[`TFT_CTRL_AUTO] ? (i_eot & ~eot_q) : rewind_press;
      o_rewind_unload <= unload_press & (go_d == 1'b0) & (motion != `TFT_MOT_START) & (motion != `TFT_MOT_GO);
      o_set_nrzi <= ~pe_eff;
    end
  end

  // write frequency per model.
  // A square wave at the model's rate; it runs freely so track data is steady.
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wp_cnt_q <= 12'h000;
      o_write_pulse <= 1'b0;
    end else if (wp_cnt_q >= wp_half - 12'h001) begin
      wp_cnt_q <= 12'h000;
      o_write_pulse <= ~o_write_pulse;
    end else begin
      wp_cnt_q <= wp_cnt_q + 12'h001;
    end
  end

  // zero tracks erase.
  // Write bus only carries ones while writing forward with tape moving.
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_write_bus <= 9'h000;
    end else if (fwd_ready & ctrl_q[`TFT_CTRL_WRITE] & go_d) begin
      o_write_bus <= tracks_q;
    end else begin
      o_write_bus <= 9'h000;
    end
  end

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_scan1 <= 1'b0;
      o_scan2 <= 1'b0;
    end else begin
      o_scan1 <= scan_pick(i_read_bus, scan_q[`TFT_SCAN1]);
      o_scan2 <= scan_pick(i_read_bus, scan_q[`TFT_SCAN2]);
    end
  end
endmodule

/* rtl/tft_defs.vh */
// Purpose: Constants shared by the field tester control logic.
// Assumes: 50 MHz system clock.
// Notes: Offsets are byte addresses on the classic Wishbone slave.
`ifndef TFT_DEFS_VH
`define TFT_DEFS_VH

// Clock period and time units.
`define TFT_CLK_NS 20
`define TFT_MS_NS 1000000
`define TFT_DEB_MS 10
`define TFT_LONG_UNIT_MS 20'h0000A
`define TFT_MS_CYCLES 20'h0C350
`define TFT_DEB_CYCLES 20'h7A120

// Go-up and go-down limits, in ms (short) or 10 ms units (long).
`define TFT_SHORT_MIN 10'h002
`define TFT_SHORT_MAX 10'h01E
`define TFT_LONG_MIN 10'h01E
`define TFT_LONG_MAX 10'h258
`define TFT_DUR_RESET 10'h00A

// Register byte offsets.
`define TFT_REG_CTRL 8'h00
`define TFT_REG_GO_UP 8'h04
`define TFT_REG_GO_DOWN 8'h08
`define TFT_REG_TRACKS 8'h0C
`define TFT_REG_SCAN 8'h10
`define TFT_REG_STATUS 8'h14

// Control register fields.
`define TFT_CTRL_MOTION 1:0
`define TFT_CTRL_BACKWARD 2
`define TFT_CTRL_WRITE 3
`define TFT_CTRL_AUTO 4
`define TFT_CTRL_LONG 5
`define TFT_CTRL_PE 6
`define TFT_CTRL_MODEL 9:7
`define TFT_CTRL_W 10
`define TFT_CTRL_RESET 10'h000

// Scan register fields.
`define TFT_SCAN1 3:0
`define TFT_SCAN2 7:4
`define TFT_SCAN_RESET 8'h00
`define TFT_TRACKS_RESET 9'h000
`define TFT_NUM_TRACKS 4'h9

// Motion selector codes; code 3 behaves as stop.
`define TFT_MOT_STOP 2'h0
`define TFT_MOT_START 2'h1
`define TFT_MOT_GO 2'h2

// Model codes 0..5 stand for models 1..6; from this code on PE is possible.
`define TFT_MODEL_FIRST_PE 3'h3

// Write pulse half periods in clock cycles, per model code.
`define TFT_WP_HALF_M1 12'h064
`define TFT_WP_HALF_M2 12'h046
`define TFT_WP_HALF_M3 12'h032
`define TFT_WP_HALF_M4 12'h032
`define TFT_WP_HALF_M5 12'h023
`define TFT_WP_HALF_M6 12'h019

`endif

/* rtl/tft_debounce.v */
// Purpose: Debounce a spring-loaded switch and give one pulse per press.
// Assumes: Switch level is synchronous to the clock, active high.
// Notes: The press must be stable for DEB_CYCLES before it counts.
`timescale 1ns/10ps
module tft_debounce #(
  parameter [19:0] DEB_CYCLES = 20'h7A120
) (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_sw,
  output reg o_press
);
  reg [19:0] cnt_q;
  reg stable_q;

  // one pulse per press.
  // A level change restarts the count, so contact bounce never reaches the output.
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= 20'h00000;
      stable_q <= 1'b0;
      o_press <= 1'b0;
    end else begin
      o_press <= 1'b0;
      if (i_sw == stable_q) begin
        cnt_q <= 20'h00000;
      end else if (cnt_q >= DEB_CYCLES - 20'h00001) begin
        cnt_q <= 20'h00000;
        stable_q <= i_sw;
        o_press <= i_sw;
      end else begin
        cnt_q <= cnt_q + 20'h00001;
      end
    end
  end
endmodule

/* tb/tft_ctrl_properties.sv */
// Purpose: Port-level assertions for the tape tester control block.
// Assumes: One clock, reset asynchronous and active high.
// Notes: Sees only the top ports; attached by the bind below.
`timescale 1ns/10ps
module tft_ctrl_chk (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire o_wb_ack,
  input wire i_ready,
  input wire o_go,
  input wire o_go_hub,
  input wire o_backward,
  input wire o_set_read,
  input wire o_set_write,
  input wire o_rewind,
  input wire o_rewind_unload,
  input wire [8:0] o_write_bus
);
  // All checks share one clock, so the reset is applied once here.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  // A taken request and its single-cycle answer.
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ack;
    o_wb_ack ##1 !o_wb_ack;
  endsequence

  chk_bus_answer: assert property (s_req |=> s_ack) else $error("bus answer late");
  chk_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
  chk_status_excl: assert property (!(o_set_read && o_set_write)) else $error("both status lines");
  chk_status_ready: assert property ((o_set_read || o_set_write) |-> $past(i_ready)) else $error("status not ready");
  chk_back_mute: assert property (o_backward |-> !o_set_read && !o_set_write) else $error("status in backward");
  chk_write_gate: assert property ((o_write_bus != 9'h000) |-> $past(i_ready) && !o_backward) else $error("write bus");
  chk_rewind_pulse: assert property (o_rewind |=> !o_rewind) else $error("rewind not a pulse");
  chk_unload_stop: assert property (o_rewind_unload |-> !o_go ##1 !o_rewind_unload) else $error("unload bad");
  chk_hub_follow: assert property ($rose(o_go) |-> ##[0:1] o_go_hub) else $error("go hub lags");
endmodule

bind tft_ctrl tft_ctrl_chk u_chk (.i_sys_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_ready, .o_go,
  .o_go_hub, .o_backward, .o_set_read, .o_set_write, .o_rewind, .o_rewind_unload, .o_write_bus);

/* tb/tft_tape_model.sv */
// Purpose: Behavioural tape unit on the far side of the tester.
// Assumes: Tape position counts clock cycles of forward motion.
// Notes: Unload is treated as a plain rewind; nothing is unthreaded.
`timescale 1ns/10ps
module tft_tape_model #(
  parameter int EOT_POS = 400,
  parameter int REW_CYC = 20
) (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_online,
  input wire i_go,
  input wire i_backward,
  input wire i_rewind,
  input wire i_rewind_unload,
  output logic o_ready,
  output logic o_eot,
  output logic [8:0] o_read_bus
);
  int pos_q;
  int busy_q;

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pos_q <= 0;
      busy_q <= 0;
      o_read_bus <= 9'h000;
    end else begin
      // Read buses change every cycle so a stale selection shows up.
      o_read_bus <= {o_read_bus[7:0], ~o_read_bus[8]};
      if ((i_rewind || i_rewind_unload) && o_ready) begin
        busy_q <= REW_CYC;
      end else if (busy_q > 0) begin
        busy_q <= busy_q - 1;
        if (busy_q == 1) pos_q <= 0;
      end else if (i_go && o_ready) begin
        pos_q <= i_backward ? (pos_q > 0 ? pos_q - 1 : 0) : pos_q + 1;
      end
    end
  end

  // A rewinding unit is not ready; the marker shows at and past the end position.
  assign o_ready = i_online && busy_q == 0;
  assign o_eot = pos_q >= EOT_POS;
endmodule

/* tb/tb.sv */
// Purpose: Self-checking bench for the tape tester control block.
// Assumes: Short parameters keep every timed phase brief.
// Notes: Expected register values come from a shadow array.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb;
  logic i_sys_clk = 0, i_reset = 1, cyc = 0, stb = 0, we = 0, rew_sw = 0, unl_sw = 0, online = 1, v;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, q;
  logic [8:0] rb_q, trk;
  logic [11:0] c;
  wire [31:0] rdat;
  wire [8:0] rbus, wbus;
  wire ack, rdy, eot, go, bkw, srd, swr, rew, unl, wp, nrzi, sc1, sc2, hub;
  int fail_count = 0, compares = 0, seed = 37, rew_cnt = 0, unl_cnt = 0, n, hi, lo, exp_w;
  // Reference model of the track switches: each setting queued as written, popped when it must show.
  int trk_q[$];
  int m[7];
  int half[6] = '{100, 70, 50, 50, 35, 25};

  always #10 i_sys_clk = ~i_sys_clk;

  // Pulses are counted on the edge that sees them, once each.
  always @(posedge i_sys_clk) begin
    rb_q <= rbus;
    if (rew === 1'b1) rew_cnt <= rew_cnt + 1;
    if (unl === 1'b1) unl_cnt <= unl_cnt + 1;
  end

  tft_ctrl #(.MS_CYCLES(20'h0000A), .DEB_CYCLES(20'h00004)) uut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(4'hF),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_rewind_sw(rew_sw), .i_unload_sw(unl_sw), .i_ready(rdy), .i_eot(eot),
    .i_read_bus(rbus), .o_go(go), .o_backward(bkw), .o_set_read(srd), .o_set_write(swr), .o_rewind(rew),
    .o_rewind_unload(unl), .o_write_bus(wbus), .o_write_pulse(wp), .o_set_nrzi(nrzi), .o_scan1(sc1),
    .o_scan2(sc2), .o_go_hub(hub));

  tft_tape_model tape (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_online(online), .i_go(go),
    .i_backward(bkw), .i_rewind(rew), .i_rewind_unload(unl), .o_ready(rdy), .o_eot(eot), .o_read_bus(rbus));

  task end_of_test;
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One classic cycle; a missing ack is cut short by the bound.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_sys_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    k = 0;
    do begin @(posedge i_sys_clk); k++; end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin fail_count++; end_of_test; end
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask

  task cyc_n(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask

  // Counts cycles while go or the write pulse keeps the given level.
  task run(input bit s, input logic lvl, output int k);
    k = 0;
    while ((s ? wp : go) === lvl && k < 9000) begin cyc_n(1); k++; end
    if (k >= 9000) begin fail_count++; end_of_test; end
  endtask

  task press(input bit u);
    @(posedge i_sys_clk);
    if (u) unl_sw <= 1;
    else rew_sw <= 1;
    repeat (8) @(posedge i_sys_clk);
    rew_sw <= 0;
    unl_sw <= 0;
    cyc_n(30);
  endtask

  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_reset <= 0;
    m = '{0, 10, 10, 0, 0, 0, 0};
    // Reset values, including an unmapped offset past the status register.
    for (int i = 0; i < 7; i++) if (i != 5) begin wb(0, 8'(i * 4), 0); `CHK(q, m[i]) end
    wb(1, 8'h00, 32'h0A);
    for (int k = 0; k < 16; k++) begin
      trk = 9'($random(seed));
      trk_q.push_back(int'(trk));
      wb(1, 8'h0C, {23'h0, trk});
      wb(1, 8'h10, {24'h0, 4'(15 - k), 4'(k)});
      cyc_n(3);
      exp_w = trk_q.pop_front();
      `CHK(wbus, exp_w)
      `CHK({go, hub}, 2'b11)
      `CHK(sc1, k < 9 ? rb_q[k] : 1'b0)
      `CHK(sc2, 15 - k < 9 ? rb_q[15 - k] : 1'b0)
    end
    // Direction and read/write settings in every combination.
    for (int i = 0; i < 4; i++) begin
      c = 12'h002 | 12'(i * 4);
      wb(1, 8'h00, {20'h0, c});
      cyc_n(3);
      `CHK({bkw, srd, swr}, {c[2], ~c[2] & ~c[3], ~c[2] & c[3]})
    end
    // Forward write first, so that losing ready has something to take away.
    wb(1, 8'h00, 32'h0A);
    cyc_n(3);
    `CHK({srd, swr}, 2'b01)
    @(posedge i_sys_clk);
    online <= 0;
    cyc_n(3);
    `CHK({srd, swr, wbus}, 11'h000)
    @(posedge i_sys_clk);
    online <= 1;
    for (int i = 0; i < 4; i += 3) begin
      wb(1, 8'h00, 32'(i));
      cyc_n(3);
      `CHK(go, 1'b0)
    end
    // Intermittent motion, short range then long range, with clamped settings.
    wb(1, 8'h04, 32'h1);
    wb(1, 8'h08, 32'h3);
    for (int r = 0; r < 2; r++) begin
      wb(1, 8'h00, r ? 32'h21 : 32'h01);
      run(0, 1, n);
      run(0, 0, n);
      run(0, 1, hi);
      run(0, 0, lo);
      `CHK(hi, r ? 3000 : 20)
      `CHK(lo, r ? 3000 : 30)
    end
    // Spring switches under each gating condition, then end-of-tape cycling.
    wb(1, 8'h00, 32'h0);
    press(0);
    `CHK(rew_cnt, 1)
    press(1);
    `CHK(unl_cnt, 1)
    wb(1, 8'h00, 32'h02);
    press(1);
    `CHK(unl_cnt, 1)
    wb(1, 8'h00, 32'h10);
    press(0);
    `CHK(rew_cnt, 1)
    wb(1, 8'h00, 32'h12);
    for (n = 0; rew_cnt < 2 && n < 2000; n++) cyc_n(1);
    `CHK(rew_cnt, 2)
    if (n >= 2000) end_of_test;
    // Each model code with the phase-encoded request set.
    for (int md = 0; md < 6; md++) begin
      wb(1, 8'h00, {22'h0, 3'(md), 7'h40});
      cyc_n(3);
      `CHK(nrzi, md < 3)
      v = wp;
      run(1, v, n);
      v = wp;
      run(1, v, n);
      `CHK(n, half[md])
    end
    end_of_test;
  end
endmodule
